/* File: verilog/mcsg_cfg.svh */
// Constants of the monitor command and security gate.
`ifndef MCSG_CFG_SVH
`define MCSG_CFG_SVH

`define MCSG_DIV_EXT     9'h100
`define MCSG_DIV_INT     9'h14F
`define MCSG_GAP_BITS    2
`define MCSG_FRAME_BITS  4'hA
`define MCSG_SEC_BASE    16'hFFF6
`define MCSG_SEC_LAST    3'h7
`define MCSG_FLAG_ADDR   16'h0080
`define MCSG_FLAG_MASK   8'h40
`define MCSG_OP_STACK_POINTER_READ_CMD   8'h0C
`define MCSG_OP_RUN      8'h28
`define MCSG_OP_INDEXED_READ_CMD    8'h1A
`define MCSG_OP_INDEXED_WRITE_CMD   8'h19
`define MCSG_ROM_BASE    16'hC000
`define MCSG_BAD_DATA    8'hAD

`endif

/* File: verilog/mcsg_pkg.sv */
// Types of the monitor command and security gate.
package mcsg_pkg;

  typedef enum logic [4:0] {
    ST_SWI, ST_PUSH_INDEX_HIGH, ST_SEC_RX, ST_SEC_WT, ST_SEC_CMP, ST_FLG_RD, ST_FLG_WT,
    ST_FLG_WR, ST_BRK, ST_CMD, ST_WR_DAT, ST_IRD, ST_IRD_WT, ST_IRD_LAT,
    ST_IRD_PUSH, ST_SP_HI, ST_SP_LO, ST_POP_INDEX_HIGH, ST_RTI, ST_USER
  } mcsg_cmd_st_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_WAITHI} mcsg_rx_st_t;

  typedef enum logic [1:0] {TX_IDLE, TX_GAP, TX_BITS} mcsg_tx_st_t;

endpackage : mcsg_pkg

/* File: verilog/mcsg_stream_if.sv */
// Valid and ready stream from the command logic to the transmit buffer and from the buffer to the transmitter.
`timescale 1ns/1ps
interface mcsg_stream_if #(
  parameter int W = 9
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : mcsg_stream_if

/* File: verilog/mcsg_buf.sv */
// Small buffer that holds transmit items while the serial line is busy.
`timescale 1ns/1ps
module mcsg_buf #(
  parameter int W     = 9,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Filling and draining sides.
  mcsg_stream_if.snk in_s,
  mcsg_stream_if.src out_s
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_ff     [DEPTH];
  logic [W-1:0]  nxt_mem    [DEPTH];
  logic [PW-1:0] wp_ff;
  logic [PW-1:0] nxt_wp;
  logic [PW-1:0] rp_ff;
  logic [PW-1:0] nxt_rp;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          do_wr;
  logic          do_rd;

  assign in_s.ready  = (cnt_ff != CW'(DEPTH));
  assign out_s.valid = (cnt_ff != '0);
  assign out_s.data  = mem_ff[rp_ff];

  always_comb begin
    do_wr   = in_s.valid && in_s.ready;
    do_rd   = out_s.valid && out_s.ready;
    nxt_mem = mem_ff;
    nxt_wp  = wp_ff;
    nxt_rp  = rp_ff;
    nxt_cnt = cnt_ff;
    if (do_wr) begin
      nxt_mem[wp_ff] = in_s.data;
      nxt_wp = (wp_ff == PW'(DEPTH - 1)) ? '0 : PW'(wp_ff + 1'b1);
    end
    if (do_rd) begin
      nxt_rp = (rp_ff == PW'(DEPTH - 1)) ? '0 : PW'(rp_ff + 1'b1);
    end
    if (do_wr && !do_rd) begin
      nxt_cnt = CW'(cnt_ff + 1'b1);
    end else if (do_rd && !do_wr) begin
      nxt_cnt = CW'(cnt_ff - 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      mem_ff <= nxt_mem;
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : mcsg_buf

/* File: verilog/mcsg_top.sv */
// Monitor command interpreter with ROM security gate on a single-wire line.
`timescale 1ns/1ps
`include "mcsg_cfg.svh"
module mcsg_top #(
  parameter int BUF_DEPTH = 2
) (
  // Clock and power-on reset.
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Other resets and mode straps.
  input  wire logic        soft_rst_i,
  input  wire logic        osc_int_i,
  input  wire logic        mon_entry_i,
  // Serial line.
  input  wire logic        serial_io_pin_i,
  output logic             serial_io_pin_o,
  output logic             serial_io_pin_oe_o,
  // Memory port, read data valid one clock after the read strobe.
  output logic [15:0]      mem_addr_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic [7:0]       mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i,
  // Processor side.
  input  wire logic [15:0] sp_i,
  input  wire logic        fetch_vld_i,
  input  wire logic [15:0] fetch_addr_i,
  output logic             software_interrupt_o,
  output logic             push_index_high_o,
  output logic             pop_index_high_o,
  output logic             return_from_interrupt_o,
  output logic             illegal_addr_reset_o,
  output logic             unlocked_o
);

  function automatic logic in_rom(input logic [15:0] a);
    in_rom = (a >= `MCSG_ROM_BASE);
  endfunction : in_rom

  mcsg_stream_if #(.W(9)) push_s ();
  mcsg_stream_if #(.W(9)) pull_s ();

  mcsg_buf #(.W(9), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .in_s     (push_s),
    .out_s    (pull_s)
  );

  logic [8:0] bit_div;
  assign bit_div = osc_int_i ? `MCSG_DIV_INT : `MCSG_DIV_EXT;

  // Receiver; a change on the pin counts once the second and third stage agree.
  logic                 s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl;
  mcsg_pkg::mcsg_rx_st_t rx_st_ff, nxt_rx_st;
  logic [8:0]           rx_cnt_ff, nxt_rx_cnt;
  logic [3:0]           rx_nb_ff, nxt_rx_nb;
  logic [8:0]           rx_sh_ff, nxt_rx_sh;
  logic                 rx_done, rx_brk, rx_en;
  logic [8:0]           rx_new;

  always_comb begin
    nxt_lvl    = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
    nxt_rx_st  = rx_st_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_nb  = rx_nb_ff;
    nxt_rx_sh  = rx_sh_ff;
    rx_done    = 1'b0;
    rx_brk     = 1'b0;
    rx_new     = {lvl_ff, rx_sh_ff[8:1]};
    case (rx_st_ff)
      mcsg_pkg::RX_IDLE: begin
        if (rx_en && !lvl_ff) begin
          nxt_rx_st  = mcsg_pkg::RX_START;
          nxt_rx_cnt = {1'b0, bit_div[8:1]};
        end
      end
      mcsg_pkg::RX_START: begin
        if (rx_cnt_ff != 9'h000) begin
          nxt_rx_cnt = rx_cnt_ff - 9'h001;
        end else if (lvl_ff) begin
          nxt_rx_st = mcsg_pkg::RX_IDLE;
        end else begin
          nxt_rx_st  = mcsg_pkg::RX_DATA;
          nxt_rx_cnt = bit_div - 9'h001;
          nxt_rx_nb  = 4'h0;
        end
      end
      mcsg_pkg::RX_DATA: begin
        if (rx_cnt_ff != 9'h000) begin
          nxt_rx_cnt = rx_cnt_ff - 9'h001;
        end else begin
          nxt_rx_sh  = rx_new;
          nxt_rx_nb  = rx_nb_ff + 4'h1;
          nxt_rx_cnt = bit_div - 9'h001;
          if (rx_nb_ff == 4'h8) begin
            rx_brk    = !lvl_ff && (rx_new[7:0] == 8'h00);
            rx_done   = lvl_ff || rx_brk;
            nxt_rx_st = lvl_ff ? mcsg_pkg::RX_IDLE : mcsg_pkg::RX_WAITHI;
          end
        end
      end
      mcsg_pkg::RX_WAITHI: begin
        if (lvl_ff) begin
          nxt_rx_st = mcsg_pkg::RX_IDLE;
        end
      end
      default: nxt_rx_st = mcsg_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_ff     <= 1'b1;
      s2_ff     <= 1'b1;
      s3_ff     <= 1'b1;
      lvl_ff    <= 1'b1;
      rx_st_ff  <= mcsg_pkg::RX_IDLE;
      rx_cnt_ff <= 9'h000;
      rx_nb_ff  <= 4'h0;
      rx_sh_ff  <= 9'h000;
    end else begin
      s1_ff     <= serial_io_pin_i;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      lvl_ff    <= nxt_lvl;
      rx_st_ff  <= nxt_rx_st;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_nb_ff  <= nxt_rx_nb;
      rx_sh_ff  <= nxt_rx_sh;
    end
  end

  // Transmitter; every item is preceded by two bit times of driven high line.
  mcsg_pkg::mcsg_tx_st_t tx_st_ff, nxt_tx_st;
  logic [9:0]           tx_cnt_ff, nxt_tx_cnt;
  logic [3:0]           tx_nb_ff, nxt_tx_nb;
  logic [9:0]           tx_sh_ff, nxt_tx_sh;
  logic                 nxt_pin, nxt_oe;

  // Our own transmission echoes on the shared wire, so listen only when silent.
  assign rx_en        = (tx_st_ff == mcsg_pkg::TX_IDLE) && !pull_s.valid;
  assign pull_s.ready = (tx_st_ff == mcsg_pkg::TX_IDLE);

  always_comb begin
    nxt_tx_st  = tx_st_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_nb  = tx_nb_ff;
    nxt_tx_sh  = tx_sh_ff;
    nxt_pin    = 1'b1;
    nxt_oe     = 1'b0;
    case (tx_st_ff)
      mcsg_pkg::TX_IDLE: begin
        if (pull_s.valid) begin
          nxt_tx_st  = mcsg_pkg::TX_GAP;
          nxt_tx_cnt = 10'(`MCSG_GAP_BITS * bit_div) - 10'h001;
          nxt_tx_sh  = pull_s.data[8] ? 10'h000 : {1'b1, pull_s.data[7:0], 1'b0};
          nxt_oe     = 1'b1;
        end
      end
      mcsg_pkg::TX_GAP: begin
        nxt_oe = 1'b1;
        if (tx_cnt_ff != 10'h000) begin
          nxt_tx_cnt = tx_cnt_ff - 10'h001;
        end else begin
          nxt_tx_st  = mcsg_pkg::TX_BITS;
          nxt_tx_cnt = {1'b0, bit_div} - 10'h001;
          nxt_tx_nb  = 4'h0;
          nxt_pin    = tx_sh_ff[0];
        end
      end
      mcsg_pkg::TX_BITS: begin
        nxt_oe  = 1'b1;
        nxt_pin = tx_sh_ff[0];
        if (tx_cnt_ff != 10'h000) begin
          nxt_tx_cnt = tx_cnt_ff - 10'h001;
        end else if (tx_nb_ff == `MCSG_FRAME_BITS - 4'h1) begin
          nxt_tx_st = mcsg_pkg::TX_IDLE;
          nxt_oe    = 1'b0;
          nxt_pin   = 1'b1;
        end else begin
          nxt_tx_sh  = {1'b1, tx_sh_ff[9:1]};
          nxt_tx_nb  = tx_nb_ff + 4'h1;
          nxt_tx_cnt = {1'b0, bit_div} - 10'h001;
          nxt_pin    = tx_sh_ff[1];
        end
      end
      default: nxt_tx_st = mcsg_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_st_ff           <= mcsg_pkg::TX_IDLE;
      tx_cnt_ff          <= 10'h000;
      tx_nb_ff           <= 4'h0;
      tx_sh_ff           <= 10'h3FF;
      serial_io_pin_o    <= 1'b1;
      serial_io_pin_oe_o <= 1'b0;
    end else begin
      tx_st_ff           <= nxt_tx_st;
      tx_cnt_ff          <= nxt_tx_cnt;
      tx_nb_ff           <= nxt_tx_nb;
      tx_sh_ff           <= nxt_tx_sh;
      serial_io_pin_o    <= nxt_pin;
      serial_io_pin_oe_o <= nxt_oe;
    end
  end

  // Command sequencer.
  mcsg_pkg::mcsg_cmd_st_t st_ff, nxt_st;
  logic        pend_ff, nxt_pend, pbrk_ff, nxt_pbrk, take;
  logic [7:0]  pbyte_ff, nxt_pbyte, tmp_ff, nxt_tmp;
  logic [2:0]  cnt_ff, nxt_cnt;
  logic        ok_ff, nxt_ok, unl_ff, nxt_unl, need_ff, nxt_need;
  logic [15:0] ptr_ff, nxt_ptr, nxt_addr, sp_inc;
  logic        nxt_rd, nxt_wr, nxt_swi, nxt_push_index_high, nxt_pop_index_high, nxt_rti, nxt_ill;
  logic [7:0]  nxt_wdata;
  logic        can_push;

  assign sp_inc   = 16'(sp_i + 16'h0001);
  assign can_push = pend_ff && push_s.ready;

  always_comb begin
    nxt_pbrk  = rx_done ? rx_brk : pbrk_ff;
    nxt_pbyte = rx_done ? rx_new[7:0] : pbyte_ff;
    nxt_st    = st_ff;
    nxt_tmp   = tmp_ff;
    nxt_cnt   = cnt_ff;
    nxt_ok    = ok_ff;
    nxt_unl   = unl_ff;
    nxt_need  = need_ff;
    nxt_ptr   = ptr_ff;
    nxt_addr  = mem_addr_o;
    nxt_wdata = mem_wdata_o;
    nxt_rd    = 1'b0;
    nxt_wr    = 1'b0;
    nxt_swi   = 1'b0;
    nxt_push_index_high  = 1'b0;
    nxt_pop_index_high  = 1'b0;
    nxt_rti   = 1'b0;
    nxt_ill   = fetch_vld_i && !unl_ff && in_rom(fetch_addr_i);
    take        = 1'b0;
    push_s.valid = 1'b0;
    push_s.data  = {pbrk_ff, pbyte_ff};
    case (st_ff)
      mcsg_pkg::ST_SWI: begin
        nxt_swi = 1'b1;
        nxt_st  = mcsg_pkg::ST_PUSH_INDEX_HIGH;
      end
      mcsg_pkg::ST_PUSH_INDEX_HIGH: begin
        nxt_push_index_high = 1'b1;
        nxt_cnt  = 3'h0;
        nxt_ok   = 1'b1;
        nxt_st   = need_ff ? mcsg_pkg::ST_SEC_RX : mcsg_pkg::ST_BRK;
      end
      mcsg_pkg::ST_SEC_RX: begin
        if (pend_ff && pbrk_ff) begin
          take = 1'b1;
        end else if (can_push) begin
          take         = 1'b1;
          push_s.valid = 1'b1;
          nxt_tmp      = pbyte_ff;
          nxt_addr     = 16'(`MCSG_SEC_BASE + {13'h0000, cnt_ff});
          nxt_rd       = 1'b1;
          nxt_st       = mcsg_pkg::ST_SEC_WT;
        end
      end
      mcsg_pkg::ST_SEC_WT: nxt_st = mcsg_pkg::ST_SEC_CMP;
      mcsg_pkg::ST_SEC_CMP: begin
        nxt_ok  = ok_ff && (mem_rdata_i == tmp_ff);
        nxt_cnt = cnt_ff + 3'h1;
        nxt_st  = (cnt_ff == `MCSG_SEC_LAST) ? mcsg_pkg::ST_FLG_RD : mcsg_pkg::ST_SEC_RX;
      end
      mcsg_pkg::ST_FLG_RD: begin
        nxt_addr = `MCSG_FLAG_ADDR;
        nxt_rd   = 1'b1;
        nxt_st   = mcsg_pkg::ST_FLG_WT;
      end
      mcsg_pkg::ST_FLG_WT: nxt_st = mcsg_pkg::ST_FLG_WR;
      mcsg_pkg::ST_FLG_WR: begin
        nxt_wr    = 1'b1;
        nxt_wdata = ok_ff ? (mem_rdata_i | `MCSG_FLAG_MASK)
                          : (mem_rdata_i & ~`MCSG_FLAG_MASK);
        nxt_unl   = ok_ff;
        nxt_need  = 1'b0;
        nxt_st    = mcsg_pkg::ST_BRK;
      end
      mcsg_pkg::ST_BRK: begin
        push_s.data  = 9'h100;
        push_s.valid = 1'b1;
        if (push_s.ready) begin
          nxt_st = mcsg_pkg::ST_CMD;
        end
      end
      mcsg_pkg::ST_CMD: begin
        if (can_push) begin
          take         = 1'b1;
          push_s.valid = 1'b1;
          nxt_cnt      = 3'h0;
          if (!pbrk_ff) begin
            case (pbyte_ff)
              `MCSG_OP_STACK_POINTER_READ_CMD: nxt_st = mcsg_pkg::ST_SP_HI;
              `MCSG_OP_RUN:    nxt_st = mcsg_pkg::ST_POP_INDEX_HIGH;
              `MCSG_OP_INDEXED_READ_CMD:  nxt_st = mcsg_pkg::ST_IRD;
              `MCSG_OP_INDEXED_WRITE_CMD: nxt_st = mcsg_pkg::ST_WR_DAT;
              default:         nxt_st = mcsg_pkg::ST_CMD;
            endcase
          end
        end
      end
      mcsg_pkg::ST_WR_DAT: begin
        if (can_push) begin
          take         = 1'b1;
          push_s.valid = 1'b1;
          nxt_st       = mcsg_pkg::ST_CMD;
          if (!pbrk_ff) begin
            nxt_addr  = ptr_ff;
            nxt_wdata = pbyte_ff;
            nxt_wr    = 1'b1;
            nxt_ptr   = 16'(ptr_ff + 16'h0001);
          end
        end
      end
      mcsg_pkg::ST_IRD: begin
        nxt_addr = ptr_ff;
        nxt_rd   = 1'b1;
        nxt_st   = mcsg_pkg::ST_IRD_WT;
      end
      mcsg_pkg::ST_IRD_WT: nxt_st = mcsg_pkg::ST_IRD_LAT;
      mcsg_pkg::ST_IRD_LAT: begin
        nxt_tmp = (!unl_ff && in_rom(mem_addr_o)) ? `MCSG_BAD_DATA : mem_rdata_i;
        nxt_st  = mcsg_pkg::ST_IRD_PUSH;
      end
      mcsg_pkg::ST_IRD_PUSH: begin
        push_s.data  = {1'b0, tmp_ff};
        push_s.valid = 1'b1;
        if (push_s.ready) begin
          nxt_ptr = 16'(ptr_ff + 16'h0001);
          nxt_cnt = cnt_ff + 3'h1;
          nxt_st  = (cnt_ff == 3'h1) ? mcsg_pkg::ST_CMD : mcsg_pkg::ST_IRD;
        end
      end
      mcsg_pkg::ST_SP_HI: begin
        push_s.data  = {1'b0, sp_inc[15:8]};
        push_s.valid = 1'b1;
        if (push_s.ready) begin
          nxt_st = mcsg_pkg::ST_SP_LO;
        end
      end
      mcsg_pkg::ST_SP_LO: begin
        push_s.data  = {1'b0, sp_inc[7:0]};
        push_s.valid = 1'b1;
        if (push_s.ready) begin
          nxt_st = mcsg_pkg::ST_CMD;
        end
      end
      mcsg_pkg::ST_POP_INDEX_HIGH: begin
        // Resume only once the echo has left, so the host sees it before the line goes quiet.
        if (!pull_s.valid && (tx_st_ff == mcsg_pkg::TX_IDLE)) begin
          nxt_pop_index_high = 1'b1;
          nxt_st   = mcsg_pkg::ST_RTI;
        end
      end
      mcsg_pkg::ST_RTI: begin
        nxt_rti = 1'b1;
        nxt_st  = mcsg_pkg::ST_USER;
      end
      mcsg_pkg::ST_USER: begin
        if (pend_ff) begin
          take = 1'b1;
        end
        if (mon_entry_i) begin
          nxt_st = mcsg_pkg::ST_SWI;
        end
      end
      default: nxt_st = mcsg_pkg::ST_SWI;
    endcase
    // Decided once take is known; a byte arriving as it is cleared is kept.
    nxt_pend = rx_done ? 1'b1 : (take ? 1'b0 : pend_ff);
    if (soft_rst_i) begin
      nxt_st       = mcsg_pkg::ST_SWI;
      nxt_pend     = 1'b0;
      push_s.valid = 1'b0;
      nxt_rd       = 1'b0;
      nxt_wr       = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff                   <= mcsg_pkg::ST_SWI;
      pend_ff                 <= 1'b0;
      pbrk_ff                 <= 1'b0;
      pbyte_ff                <= 8'h00;
      tmp_ff                  <= 8'h00;
      cnt_ff                  <= 3'h0;
      ok_ff                   <= 1'b0;
      unl_ff                  <= 1'b0;
      need_ff                 <= 1'b1;
      ptr_ff                  <= 16'h0000;
      mem_addr_o              <= 16'h0000;
      mem_wdata_o             <= 8'h00;
      mem_rd_o                <= 1'b0;
      mem_wr_o                <= 1'b0;
      software_interrupt_o    <= 1'b0;
      push_index_high_o       <= 1'b0;
      pop_index_high_o        <= 1'b0;
      return_from_interrupt_o <= 1'b0;
      illegal_addr_reset_o    <= 1'b0;
      unlocked_o              <= 1'b0;
    end else begin
      st_ff                   <= nxt_st;
      pend_ff                 <= nxt_pend;
      pbrk_ff                 <= nxt_pbrk;
      pbyte_ff                <= nxt_pbyte;
      tmp_ff                  <= nxt_tmp;
      cnt_ff                  <= nxt_cnt;
      ok_ff                   <= nxt_ok;
      unl_ff                  <= nxt_unl;
      need_ff                 <= nxt_need;
      ptr_ff                  <= nxt_ptr;
      mem_addr_o              <= nxt_addr;
      mem_wdata_o             <= nxt_wdata;
      mem_rd_o                <= nxt_rd;
      mem_wr_o                <= nxt_wr;
      software_interrupt_o    <= nxt_swi;
      push_index_high_o       <= nxt_push_index_high;
      pop_index_high_o        <= nxt_pop_index_high;
      return_from_interrupt_o <= nxt_rti;
      illegal_addr_reset_o    <= nxt_ill;
      unlocked_o              <= nxt_unl;
    end
  end
endmodule : mcsg_top

/* File: tb/mcsg_top_monitor.sv */
// Concurrent checks on the ports of the monitor command and security gate.
`timescale 1ns/1ps
`include "mcsg_cfg.svh"
module mcsg_chk (
  // Clock, reset and strap.
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        osc_int_i,
  // Processor side.
  input  wire logic        fetch_vld_i,
  input  wire logic [15:0] fetch_addr_i,
  input  wire logic        software_interrupt_o,
  input  wire logic        push_index_high_o,
  input  wire logic        pop_index_high_o,
  input  wire logic        return_from_interrupt_o,
  input  wire logic        illegal_addr_reset_o,
  input  wire logic        unlocked_o,
  // Serial line and memory port.
  input  wire logic        serial_io_pin_o,
  input  wire logic        serial_io_pin_oe_o,
  input  wire logic [15:0] mem_addr_o,
  input  wire logic        mem_wr_o,
  input  wire logic [7:0]  mem_wdata_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [12:0] oe_cnt_ff;
  logic [12:0] nxt_oe_cnt;
  logic [12:0] bit_t;
  // A cycle count since the driver turned on avoids thousand-cycle repeats.
  assign bit_t = osc_int_i ? {4'h0, `MCSG_DIV_INT} : {4'h0, `MCSG_DIV_EXT};
  always_comb nxt_oe_cnt = serial_io_pin_oe_o ? oe_cnt_ff + 13'h0001 : 13'h0000;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oe_cnt_ff <= 13'h0000;
    end else begin
      oe_cnt_ff <= nxt_oe_cnt;
    end
  end
  property p_push_after_swi; software_interrupt_o |=> push_index_high_o; endproperty
  a_push_after_swi: assert property (p_push_after_swi) else $error("no push after swi");
  property p_rti_after_pop; pop_index_high_o |=> return_from_interrupt_o; endproperty
  a_rti_after_pop: assert property (p_rti_after_pop) else $error("no return after pop");
  property p_locked_fetch;
    fetch_vld_i && !unlocked_o && fetch_addr_i >= `MCSG_ROM_BASE |=> illegal_addr_reset_o;
  endproperty
  a_locked_fetch: assert property (p_locked_fetch) else $error("locked fetch passed");
  property p_no_free_reset;
    illegal_addr_reset_o |-> $past(fetch_vld_i) && !$past(unlocked_o)
      && $past(fetch_addr_i) >= `MCSG_ROM_BASE;
  endproperty
  a_no_free_reset: assert property (p_no_free_reset) else $error("spurious reset");
  property p_unlock_holds; unlocked_o |=> unlocked_o; endproperty
  a_unlock_holds: assert property (p_unlock_holds) else $error("unlock lost");
  property p_unlock_flag;
    $rose(unlocked_o) |-> mem_wr_o && mem_addr_o == `MCSG_FLAG_ADDR
      && (mem_wdata_o & `MCSG_FLAG_MASK) != 8'h00;
  endproperty
  a_unlock_flag: assert property (p_unlock_flag) else $error("flag not set");
  property p_idle_high; !serial_io_pin_oe_o |-> serial_io_pin_o; endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle level low");
  property p_gap_high;
    serial_io_pin_oe_o && oe_cnt_ff + 13'h0002 < 2 * bit_t |-> serial_io_pin_o;
  endproperty
  a_gap_high: assert property (p_gap_high) else $error("gap not high");
  property p_start_low;
    serial_io_pin_oe_o && oe_cnt_ff == 2 * bit_t + 13'h0002 |-> !serial_io_pin_o;
  endproperty
  a_start_low: assert property (p_start_low) else $error("no start bit");
  property p_frame_len; serial_io_pin_oe_o |-> oe_cnt_ff <= 12 * bit_t + 13'h0002; endproperty
  a_frame_len: assert property (p_frame_len) else $error("item too long");
  c_unlock: cover property ($rose(unlocked_o));
  c_run: cover property (return_from_interrupt_o);
  c_illegal: cover property (illegal_addr_reset_o);
endmodule : mcsg_chk

bind mcsg_top mcsg_chk mcsg_chk_inst (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .osc_int_i(osc_int_i),
  .fetch_vld_i(fetch_vld_i), .fetch_addr_i(fetch_addr_i),
  .software_interrupt_o(software_interrupt_o), .push_index_high_o(push_index_high_o),
  .pop_index_high_o(pop_index_high_o), .return_from_interrupt_o(return_from_interrupt_o),
  .illegal_addr_reset_o(illegal_addr_reset_o), .unlocked_o(unlocked_o),
  .serial_io_pin_o(serial_io_pin_o), .serial_io_pin_oe_o(serial_io_pin_oe_o),
  .mem_addr_o(mem_addr_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o)
);

/* File: tb/mcsg_host_model.sv */
// Debug host on the single-wire line; it only pulls low, the pull-up gives high.
`timescale 1ns/1ps
module mcsg_host #(
  parameter int BIT_T = 256
) (
  // Clock.
  input  wire logic clk_i,
  // Resolved line and host drive.
  input  wire logic line_i,
  output logic      drv_o
);
  initial drv_o = 1'b1;
  task automatic send(input logic [7:0] b, input logic brk);
    logic [9:0] frame;
    frame = brk ? 10'h000 : {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drv_o <= frame[i];
      repeat (BIT_T) @(negedge clk_i);
    end
    drv_o <= 1'b1;
  endtask : send
  // Samples at bit centres and returns after the stop bit has ended.
  task automatic recv(output logic [7:0] b, output logic brk);
    while (line_i !== 1'b0) @(negedge clk_i);
    repeat (BIT_T / 2) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_T) @(negedge clk_i);
      b[i] = line_i;
    end
    repeat (BIT_T) @(negedge clk_i);
    brk = !line_i && b == 8'h00;
    repeat (BIT_T / 2) @(negedge clk_i);
  endtask : recv
endmodule : mcsg_host

/* File: tb/tb_monitor_command_security_gate.sv */
// Self-checking bench for the monitor command and security gate.
`timescale 1ns/1ps
`include "mcsg_cfg.svh"
module tb_monitor_command_security_gate;
  localparam int BT = 256;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        soft_rst_i = 1'b0;
  logic        fetch_vld_i = 1'b0;
  logic [15:0] fetch_addr_i = 16'h0000;
  logic [15:0] sp_i = 16'h0000;
  logic [7:0]  mem_rdata_i = 8'h00;
  logic [7:0]  mem [0:65535];
  logic        serial_io_pin_o, serial_io_pin_oe_o, mem_rd_o, mem_wr_o;
  logic [15:0] mem_addr_o;
  logic [7:0]  mem_wdata_o;
  logic        software_interrupt_o, push_index_high_o, pop_index_high_o;
  logic        return_from_interrupt_o, illegal_addr_reset_o, unlocked_o;
  logic        host_drv;
  logic        rti_seen = 1'b0;
  wire         line = host_drv & (serial_io_pin_oe_o ? serial_io_pin_o : 1'b1);
  int          seed = 75;
  int          failures = 0;
  int          n_tests = 0;
  int          cycles = 0;
  always #5 clk_i = ~clk_i;
  mcsg_top #(.BUF_DEPTH(2)) mcsg_top_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .soft_rst_i(soft_rst_i), .osc_int_i(1'b0),
    .mon_entry_i(1'b0), .serial_io_pin_i(line), .serial_io_pin_o(serial_io_pin_o),
    .serial_io_pin_oe_o(serial_io_pin_oe_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .sp_i(sp_i),
    .fetch_vld_i(fetch_vld_i), .fetch_addr_i(fetch_addr_i),
    .software_interrupt_o(software_interrupt_o), .push_index_high_o(push_index_high_o),
    .pop_index_high_o(pop_index_high_o), .return_from_interrupt_o(return_from_interrupt_o),
    .illegal_addr_reset_o(illegal_addr_reset_o), .unlocked_o(unlocked_o)
  );
  mcsg_host #(.BIT_T(BT)) host_inst (.clk_i(clk_i), .line_i(line), .drv_o(host_drv));
  // Memory answers in the cycle after the read strobe.
  always @(posedge clk_i) begin
    if (mem_rd_o) mem_rdata_i <= mem[mem_addr_o];
    if (mem_wr_o) mem[mem_addr_o] <= mem_wdata_o;
    if (return_from_interrupt_o === 1'b1) rti_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      failures++;
      $display("[FAIL] %0t run did not finish", $time);
      give_verdict();
    end
  end
  // Random opcode fetches probe the ROM guard while locked and unlocked.
  always @(negedge clk_i) begin
    fetch_vld_i <= 1'($random(seed));
    fetch_addr_i <= 16'($random(seed));
  end
  function automatic logic [15:0] sp_plus_one(input logic [15:0] sp);
    return sp + 16'h0001;
  endfunction : sp_plus_one
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic [7:0] d);
    logic [7:0] e;
    logic       k;
    host_inst.send(d, 1'b0);
    host_inst.recv(e, k);
    check({7'h00, k, e}, {8'h00, d});
    repeat (BT) @(negedge clk_i);
  endtask : xfer
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] wd;
    logic       k;
    for (int i = 0; i < 65536; i++) mem[i] = 8'($random(seed));
    repeat (8) @(negedge clk_i);
    arst_n_i = 1'b1;
    for (int i = 0; i < 8; i++) xfer(mem[16'hFFF6 + i]);
    host_inst.recv(hi, k);
    check({7'h00, k, hi}, 16'h0100);
    check({15'h0000, unlocked_o}, 16'h0001);
    check({8'h00, mem[16'h0080] & 8'h40}, 16'h0040);
    $display("test security done");
    // Wait a bit time after the break so the receiver has seen the line high again.
    repeat (BT) @(negedge clk_i);
    // Corner case: the stacked program counter high byte lands on the pointer's start.
    sp_i = 16'hFFFB;
    xfer(`MCSG_OP_STACK_POINTER_READ_CMD);
    host_inst.recv(hi, k);
    host_inst.recv(lo, k);
    check({hi, lo}, sp_plus_one(sp_i));
    $display("test stack pointer done");
    wd = 8'($random(seed));
    xfer(`MCSG_OP_INDEXED_WRITE_CMD);
    xfer(wd);
    check({8'h00, mem[16'(sp_plus_one(sp_i) + 16'h0004)]}, {8'h00, wd});
    xfer(`MCSG_OP_INDEXED_READ_CMD);
    host_inst.recv(hi, k);
    host_inst.recv(lo, k);
    check({hi, lo}, {mem[1], mem[2]});
    $display("test indexed access done");
    xfer(`MCSG_OP_RUN);
    check({15'h0000, rti_seen}, 16'h0001);
    $display("test run done");
    soft_rst_i = 1'b1;
    @(negedge clk_i);
    soft_rst_i = 1'b0;
    host_inst.recv(hi, k);
    check({7'h00, k, hi}, 16'h0100);
    check({15'h0000, unlocked_o}, 16'h0001);
    $display("test warm reset done");
    arst_n_i = 1'b0;
    @(negedge clk_i);
    arst_n_i = 1'b1;
    check({15'h0000, unlocked_o}, 16'h0000);
    repeat (BT) @(negedge clk_i);
    check({15'h0000, serial_io_pin_oe_o}, 16'h0000);
    $display("test power-on relock done");
    give_verdict();
  end
endmodule : tb_monitor_command_security_gate
